// ### mrc_range_ctrl.sv
// Behaviour
// - Voltage auto ranging picks among four divider settings, 6 V to 1000 V.
// - The 660 mV range is manual only, and only with the start strap open.
// - Start strap at V- makes auto ranging start at 660 V; lower ranges manual.
// - Category strap at V-: overflow at 610.0 V, 1000 V range never used.
// - Category strap open: overflow at 1010 V in the 1000 V range.
// - Reaching the active overflow level shows overload instead of a reading.
// - AC volts with high crest: step up every 60 ms until top range.
// - Range looping over 5 s lowers the underrange threshold from 500 to 460.
// - Resistance auto ranging picks among six reference settings.
// - Multimeter current codes select auto uA, auto mA or manual 66 A.
// - Clamp current codes select auto ranges or four manual full scales.
// - Auto current uses sense inputs; manual clamp uses the adapter input.
// - Unit strap at V- blanks micro and milli symbols; board keeps it open.
// - Clamp DC current offers a zero that subtracts a captured offset.
// - Capacitance has eight ranges with per-range measurement periods.
// - Each capacitance measurement is preceded by a discharge phase.
// - Clamp capacitance skips three low ranges; protection drops top range.
// - Continuity beeps at 2 kHz below 30 ohm, or 50 ohm with protection.
// - Diode beeps below 30 mV and shows overload when open or above 2 V.
`timescale 1ns/1ps
`default_nettype none

module mrc_range_ctrl #(
   parameter int unsigned MS_CYC = mrc_pkg::MS_CYCLES,
   parameter int unsigned TONE_HALF = mrc_pkg::TONE_HALF_CYCLES
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire mrc_pkg::mrc_strap_t STRAPS,
   input wire logic [3:0] FUNCTION_CODE_PINS,
   input wire logic AC_SELECT_PIN,
   input wire logic FUNC_ALT,
   input wire logic MANUAL_EN,
   input wire logic RANGE_BTN,
   input wire logic ZERO_REQ,
   input wire logic [13:0] READING,
   input wire logic READING_VALID,
   input wire logic HIGH_CREST_DETECT,
   input wire logic DISCHARGED,
   output mrc_pkg::mrc_mode_t MODE,
   output logic [2:0] RANGE,
   output mrc_pkg::mrc_route_t ROUTE,
   output mrc_pkg::mrc_display_t DISPLAY,
   output logic [13:0] READING_OUT,
   output logic ZERO_ACTIVE,
   output logic CAP_LOW_CURRENT,
   output logic CAP_SAMPLE,
   output logic BUZZER
);
   import mrc_pkg::*;

   initial
   begin
      if (MS_CYC < 1 || MS_CYC > 65536)
         $error("mrc_range_ctrl: MS_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode.
   mrc_mode_t mode_d;
   logic clamp_code;
   logic clamp_auto;
   logic cur_dc;
   mrc_strap_t st;

   assign st = STRAPS;
   assign cur_dc = ~(AC_SELECT_PIN ^ FUNC_ALT);
   assign clamp_auto = st.unit_symbol_strap;

   always_comb
   begin
      mode_d = MD_OTHER;
      clamp_code = 1'b0;
      case (FUNCTION_CODE_PINS)
         FC_VOLT: mode_d = MD_VOLT;
         FC_AUTO_LO, FC_AUTO_HI: mode_d = MD_CUR_AUTO;
         FC_A66: mode_d = MD_CUR_MAN;
         FC_CLAMP_6A, FC_CLAMP_66A, FC_CLAMP_660A, FC_CLAMP_6600A:
         begin
            mode_d = MD_CUR_MAN;
            clamp_code = 1'b1;
         end
         FC_RES, FC_RES_ALT:
            if (!AC_SELECT_PIN)
               mode_d = FUNC_ALT ? MD_CONT : MD_RES;
         FC_CONT:
            if (!AC_SELECT_PIN)
               mode_d = FUNC_ALT ? MD_DIODE : MD_CONT;
         FC_CAP: mode_d = MD_CAP;
         default: mode_d = MD_OTHER;
      endcase
   end

   logic clamp_man_q;
   logic mode_chg;
   assign mode_chg = (mode_d != MODE);

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         MODE <= MD_OTHER;
         clamp_man_q <= 1'b0;
      end
      else
      begin
         MODE <= mode_d;
         clamp_man_q <= clamp_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Range limits per mode.
   logic [2:0] auto_min, auto_max, man_min;
   logic auto_ok;
   logic ac_volt;
   logic clamp_cap;

   assign ac_volt = (MODE == MD_VOLT) && (AC_SELECT_PIN ^ FUNC_ALT);
   assign clamp_cap = AC_SELECT_PIN;

   always_comb
   begin
      auto_min = RNG_NONE;
      auto_max = RNG_NONE;
      man_min = RNG_NONE;
      auto_ok = 1'b0;
      case (MODE)
         MD_VOLT:
         begin
            auto_ok = 1'b1;
            auto_min = st.voltage_start_strap ? RNG_V_660V : RNG_V_6V;
            man_min = st.voltage_start_strap ? RNG_V_6V : RNG_V_660MV;
            auto_max = st.overflow_category_strap ? RNG_V_660V
                                                  : RNG_V_1000V;
         end
         MD_CUR_AUTO:
         begin
            auto_ok = 1'b1;
            auto_max = 3'h1;
         end
         MD_RES:
         begin
            auto_ok = 1'b1;
            auto_max = RNG_R_TOP;
         end
         MD_DIODE:
         begin
            auto_min = RNG_V_6V;
            man_min = RNG_V_6V;
            auto_max = RNG_V_6V;
         end
         MD_CAP:
         begin
            auto_ok = 1'b1;
            auto_min = clamp_cap ? RNG_C_CLAMP_MIN : RNG_NONE;
            man_min = auto_min;
            auto_max = (clamp_cap && st.protection_strap) ? RNG_C_PROT_TOP
                                                        : RNG_C_TOP;
         end
         default:
         begin
            auto_min = RNG_NONE;
            auto_max = RNG_NONE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Millisecond tick shared by every timer.
   logic [15:0] pre_q;
   logic ms_tick;
   assign ms_tick = (pre_q == 16'(MS_CYC - 1));

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         pre_q <= 16'h0000;
      else if (ms_tick)
         pre_q <= 16'h0000;
      else
         pre_q <= pre_q + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // High crest stepping timer.
   logic [12:0] hcf_ms_q;
   logic hcf_step;
   logic hcf_arm;
   assign hcf_arm = ac_volt && !MANUAL_EN && HIGH_CREST_DETECT
                    && (RANGE < auto_max);
   assign hcf_step = hcf_arm && ms_tick && (hcf_ms_q == HCF_STEP_MS - 13'h1);

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         hcf_ms_q <= 13'h0000;
      else if (!hcf_arm || hcf_step)
         hcf_ms_q <= 13'h0000;
      else if (ms_tick)
         hcf_ms_q <= hcf_ms_q + 13'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Range selection.
   logic [13:0] ul_thr;
   logic step_up, step_dn;
   logic [2:0] range_d;
   logic ul_low_q;

   assign ul_thr = ul_low_q ? UL_LOOPING : UL_DEFAULT;
   assign step_up = auto_ok && !MANUAL_EN && (hcf_step || (READING_VALID
                    && READING > FULL_SCALE)) && (RANGE < auto_max);
   assign step_dn = auto_ok && !MANUAL_EN && !hcf_step && READING_VALID
                    && READING < ul_thr && (RANGE > auto_min)
                    && !(ac_volt && HIGH_CREST_DETECT);

   always_comb
   begin
      range_d = RANGE;
      if (mode_chg)
         range_d = RNG_NONE;
      else if (MANUAL_EN && RANGE_BTN && auto_ok)
         range_d = (RANGE >= auto_max) ? man_min : RANGE + 3'h1;
      else if (MANUAL_EN && RANGE < man_min)
         range_d = man_min;
      else if (!MANUAL_EN && RANGE < auto_min)
         range_d = auto_min;
      else if (step_up)
         range_d = RANGE + 3'h1;
      else if (step_dn)
         range_d = RANGE - 3'h1;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         RANGE <= RNG_NONE;
      else
         RANGE <= range_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Range looping watch. A reversal of step direction keeps it alive; a
   // quiet second ends it. The lowered threshold stays until mode change.
   logic last_up_q, looping_q;
   logic [12:0] loop_ms_q, quiet_ms_q;
   logic reversal;
   assign reversal = (step_up && !last_up_q) || (step_dn && last_up_q);

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         last_up_q <= 1'b0;
         looping_q <= 1'b0;
         loop_ms_q <= 13'h0000;
         quiet_ms_q <= 13'h0000;
         ul_low_q <= 1'b0;
      end
      else if (mode_chg)
      begin
         looping_q <= 1'b0;
         loop_ms_q <= 13'h0000;
         quiet_ms_q <= 13'h0000;
         ul_low_q <= 1'b0;
      end
      else
      begin
         if (step_up || step_dn)
            last_up_q <= step_up;
         if (reversal)
         begin
            looping_q <= 1'b1;
            quiet_ms_q <= 13'h0000;
         end
         else if (looping_q && ms_tick)
         begin
            if (quiet_ms_q == LOOP_QUIET_MS)
            begin
               looping_q <= 1'b0;
               loop_ms_q <= 13'h0000;
            end
            else
               quiet_ms_q <= quiet_ms_q + 13'h0001;
         end
         if (looping_q && ms_tick && loop_ms_q != LOOP_HOLD_MS)
            loop_ms_q <= loop_ms_q + 13'h0001;
         if (looping_q && loop_ms_q == LOOP_HOLD_MS)
            ul_low_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capacitance sequencing.
   mrc_cap_t cap_q;
   logic [12:0] cap_ms_q;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cap_q <= CAP_IDLE;
         cap_ms_q <= 13'h0000;
         CAP_SAMPLE <= 1'b0;
      end
      else
      begin
         CAP_SAMPLE <= 1'b0;
         if (MODE != MD_CAP || mode_chg)
            cap_q <= CAP_IDLE;
         else
            case (cap_q)
               CAP_IDLE: cap_q <= CAP_DISCH;
               CAP_DISCH:
                  if (DISCHARGED)
                  begin
                     cap_q <= CAP_MEAS;
                     cap_ms_q <= 13'h0000;
                  end
               CAP_MEAS:
                  if (range_d != RANGE)
                     cap_q <= CAP_DISCH;
                  else if (ms_tick)
                  begin
                     if (cap_ms_q == CAP_PERIOD_MS[RANGE] - 13'h1)
                     begin
                        CAP_SAMPLE <= 1'b1;
                        cap_q <= CAP_DISCH;
                     end
                     else
                        cap_ms_q <= cap_ms_q + 13'h0001;
                  end
               default: cap_q <= CAP_IDLE;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero offset for clamp DC current.
   logic [13:0] offset_q;
   logic zero_ok;
   assign zero_ok = cur_dc && ((MODE == MD_CUR_MAN && clamp_man_q)
                    || (MODE == MD_CUR_AUTO && clamp_auto));

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         offset_q <= 14'h0000;
         ZERO_ACTIVE <= 1'b0;
      end
      else if (!zero_ok || mode_chg)
      begin
         offset_q <= 14'h0000;
         ZERO_ACTIVE <= 1'b0;
      end
      else if (ZERO_REQ)
      begin
         offset_q <= ZERO_ACTIVE ? 14'h0000 : READING_OUT;
         ZERO_ACTIVE <= ~ZERO_ACTIVE;
      end
   end

   // Offsets larger than the reading clip at zero rather than wrap.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         READING_OUT <= 14'h0000;
      else if (READING_VALID)
         READING_OUT <= (READING > offset_q) ? READING - offset_q
                                             : 14'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Overload, beeper request, routing and display flags.
   logic ovl_d, beep_d, beep_q;
   mrc_route_t route_d;

   always_comb
   begin
      ovl_d = READING > FULL_SCALE
              && (MANUAL_EN || !auto_ok || RANGE >= auto_max);
      if (MODE == MD_VOLT && st.overflow_category_strap
          && RANGE == RNG_V_660V && READING >= OVF_CE_660V)
         ovl_d = 1'b1;
      if (MODE == MD_VOLT && !st.overflow_category_strap
          && RANGE == RNG_V_1000V && READING >= OVF_1000V)
         ovl_d = 1'b1;
      if (MODE == MD_DIODE && READING > DIODE_OPEN_THR)
         ovl_d = 1'b1;
      beep_d = 1'b0;
      if (MODE == MD_CONT)
         beep_d = READING < (st.protection_strap ? CONT_THR_PROT
                                                 : CONT_THR);
      if (MODE == MD_DIODE)
         beep_d = READING < DIODE_BEEP_THR;
      route_d = RT_DIVIDER;
      if (MODE == MD_CUR_AUTO)
         route_d = (RANGE == 3'h0) ? RT_SENSE_LOW : RT_SENSE_HIGH;
      else if (MODE == MD_CUR_MAN)
         route_d = clamp_man_q ? RT_ADAPTER : RT_SENSE_HIGH;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         DISPLAY <= '0;
         beep_q <= 1'b0;
         ROUTE <= RT_DIVIDER;
         CAP_LOW_CURRENT <= 1'b0;
      end
      else
      begin
         if (READING_VALID || mode_chg)
         begin
            DISPLAY.overload_flag <= ovl_d && !mode_chg;
            beep_q <= beep_d && !mode_chg;
         end
         DISPLAY.underrange_flag <= ul_low_q;
         DISPLAY.discharge_message <= (cap_q == CAP_DISCH);
         DISPLAY.unit_blank <= st.unit_symbol_strap;
         DISPLAY.fine_resolution <= (MODE == MD_RES) && (RANGE == RNG_R_TOP)
                                    && st.resolution_shift_strap_alt;
         ROUTE <= route_d;
         CAP_LOW_CURRENT <= (MODE == MD_CAP) && clamp_cap
                            && st.protection_strap;
      end
   end

   mrc_tone #(
      .HALF_CYCLES(TONE_HALF)
   ) u_tone (
      .CLK(CLK),
      .ARST_N(ARST_N),
      .EN(beep_q),
      .TONE(BUZZER)
   );

endmodule : mrc_range_ctrl

`default_nettype wire

// ### mrc_pkg.sv
package mrc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   localparam int unsigned TONE_HZ = 2000;
   localparam int unsigned TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);
   localparam logic [12:0] HCF_STEP_MS = 13'h003C;
   localparam logic [12:0] LOOP_HOLD_MS = 13'h1388;
   localparam logic [12:0] LOOP_QUIET_MS = 13'h03E8;
   localparam logic [12:0] CAP_PERIOD_MS [8] = '{13'h014A, 13'h014A,
      13'h014A, 13'h014A, 13'h0294, 13'h0528, 13'h0528, 13'h19C8};

   ////////////////////////////////////////////////////////////////////////
   // Count limits.
   localparam logic [13:0] FULL_SCALE = 14'h19C8;
   localparam logic [13:0] UL_DEFAULT = 14'h01F4;
   localparam logic [13:0] UL_LOOPING = 14'h01CC;
   localparam logic [13:0] OVF_CE_660V = 14'h17D4;
   localparam logic [13:0] OVF_1000V = 14'h03F2;
   localparam logic [13:0] CONT_THR = 14'h012C;
   localparam logic [13:0] CONT_THR_PROT = 14'h01F4;
   localparam logic [13:0] DIODE_BEEP_THR = 14'h001E;
   localparam logic [13:0] DIODE_OPEN_THR = 14'h07D0;

   ////////////////////////////////////////////////////////////////////////
   // Range indices.
   localparam logic [2:0] RNG_V_660MV = 3'h0;
   localparam logic [2:0] RNG_V_6V = 3'h1;
   localparam logic [2:0] RNG_V_660V = 3'h3;
   localparam logic [2:0] RNG_V_1000V = 3'h4;
   localparam logic [2:0] RNG_R_TOP = 3'h5;
   localparam logic [2:0] RNG_C_TOP = 3'h7;
   localparam logic [2:0] RNG_C_CLAMP_MIN = 3'h3;
   localparam logic [2:0] RNG_C_PROT_TOP = 3'h6;
   localparam logic [2:0] RNG_NONE = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Function codes, first pin in the top bit.
   localparam logic [3:0] FC_VOLT = 4'hB;
   localparam logic [3:0] FC_AUTO_LO = 4'hD;
   localparam logic [3:0] FC_AUTO_HI = 4'hF;
   localparam logic [3:0] FC_A66 = 4'h0;
   localparam logic [3:0] FC_CLAMP_6A = 4'hC;
   localparam logic [3:0] FC_CLAMP_66A = 4'h8;
   localparam logic [3:0] FC_CLAMP_660A = 4'hA;
   localparam logic [3:0] FC_CLAMP_6600A = 4'h9;
   localparam logic [3:0] FC_RES = 4'h3;
   localparam logic [3:0] FC_RES_ALT = 4'h7;
   localparam logic [3:0] FC_CONT = 4'h1;
   localparam logic [3:0] FC_CAP = 4'h6;

   typedef enum logic [7:0] {
      MD_OTHER = 8'h01,
      MD_VOLT = 8'h02,
      MD_CUR_AUTO = 8'h04,
      MD_CUR_MAN = 8'h08,
      MD_RES = 8'h10,
      MD_CONT = 8'h20,
      MD_DIODE = 8'h40,
      MD_CAP = 8'h80
   } mrc_mode_t;

   typedef enum logic [2:0] {
      CAP_IDLE = 3'h1,
      CAP_DISCH = 3'h2,
      CAP_MEAS = 3'h4
   } mrc_cap_t;

   typedef enum logic [1:0] {
      RT_DIVIDER = 2'h0,
      RT_SENSE_HIGH = 2'h1,
      RT_SENSE_LOW = 2'h2,
      RT_ADAPTER = 2'h3
   } mrc_route_t;

   // A strap bit is 1 when the pin is tied to the negative supply.
   typedef struct packed {
      logic voltage_start_strap;
      logic overflow_category_strap;
      logic resolution_shift_strap_alt;
      logic unit_symbol_strap;
      logic protection_strap;
   } mrc_strap_t;

   typedef struct packed {
      logic overload_flag;
      logic underrange_flag;
      logic discharge_message;
      logic unit_blank;
      logic fine_resolution;
   } mrc_display_t;

endpackage : mrc_pkg

// ### mrc_tone.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_tone #(
   parameter int unsigned HALF_CYCLES = 10000
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic EN,
   output logic TONE
);
   import mrc_pkg::*;

   initial
   begin
      if (HALF_CYCLES < 1 || HALF_CYCLES > 65536)
         $error("mrc_tone: HALF_CYCLES out of range");
   end

   logic [15:0] cnt_q;

   // The tone restarts from low on each enable so a beep never begins
   // with a truncated half period.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cnt_q <= 16'h0000;
         TONE <= 1'b0;
      end
      else if (!EN)
      begin
         cnt_q <= 16'h0000;
         TONE <= 1'b0;
      end
      else if (cnt_q == 16'(HALF_CYCLES - 1))
      begin
         cnt_q <= 16'h0000;
         TONE <= ~TONE;
      end
      else
         cnt_q <= cnt_q + 16'h0001;
   end

endmodule : mrc_tone

`default_nettype wire

// ### mrc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_chk #(
   parameter int unsigned TONE_HALF = 3
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire mrc_pkg::mrc_strap_t STRAPS,
   input wire logic [3:0] FUNCTION_CODE_PINS,
   input wire logic AC_SELECT_PIN,
   input wire logic FUNC_ALT,
   input wire logic MANUAL_EN,
   input wire logic [13:0] READING,
   input wire logic READING_VALID,
   input wire logic HIGH_CREST_DETECT,
   input wire mrc_pkg::mrc_mode_t MODE,
   input wire logic [2:0] RANGE,
   input wire mrc_pkg::mrc_route_t ROUTE,
   input wire mrc_pkg::mrc_display_t DISPLAY,
   input wire logic BUZZER
);
   import mrc_pkg::*;
   localparam int BZ_MAX = int'(TONE_HALF) + 4;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////
   property p_ovf_top;
      MODE == MD_VOLT && RANGE == RNG_V_1000V && READING_VALID &&
      !STRAPS.overflow_category_strap && READING >= OVF_1000V
      |=> DISPLAY.overload_flag;
   endproperty
   a_ovf_top: assert property (p_ovf_top)
      else $error("no overload at top volt range");
   property p_ce_ovf;
      MODE == MD_VOLT && RANGE == RNG_V_660V && READING_VALID &&
      STRAPS.overflow_category_strap && READING >= OVF_CE_660V
      |=> DISPLAY.overload_flag;
   endproperty
   a_ce_ovf: assert property (p_ce_ovf)
      else $error("no overload at category limit");
   property p_mv;
      (MODE == MD_VOLT && (!MANUAL_EN || STRAPS.voltage_start_strap))[*3]
      |-> RANGE != RNG_V_660MV;
   endproperty
   a_mv: assert property (p_mv)
      else $error("millivolt range outside manual");
   // Crest steps climb one range at a time.
   property p_hcf;
      MODE == MD_VOLT && $past(MODE, 2) == MD_VOLT && !MANUAL_EN &&
      AC_SELECT_PIN != FUNC_ALT && HIGH_CREST_DETECT &&
      $past(HIGH_CREST_DETECT) && RANGE != $past(RANGE)
      |-> RANGE == $past(RANGE) + 3'h1;
   endproperty
   a_hcf: assert property (p_hcf)
      else $error("crest step not one range up");
   property p_cont_beep;
      MODE == MD_CONT && READING_VALID && READING <
      (STRAPS.protection_strap ? CONT_THR_PROT : CONT_THR)
      |-> ##[1:BZ_MAX] BUZZER;
   endproperty
   a_cont_beep: assert property (p_cont_beep)
      else $error("no continuity tone");
   property p_diode_ovl;
      MODE == MD_DIODE && READING_VALID && READING > DIODE_OPEN_THR
      |=> DISPLAY.overload_flag;
   endproperty
   a_diode_ovl: assert property (p_diode_ovl)
      else $error("no diode overload");
   property p_route;
      MODE == MD_CUR_MAN && $past(MODE, 2) == MD_CUR_MAN &&
      FUNCTION_CODE_PINS[3] &&
      $past(FUNCTION_CODE_PINS, 2) == FUNCTION_CODE_PINS
      |-> ROUTE == RT_ADAPTER;
   endproperty
   a_route: assert property (p_route)
      else $error("clamp manual not on adapter");
   property p_cap_disch;
      $rose(MODE == MD_CAP) |-> ##[1:4] DISPLAY.discharge_message;
   endproperty
   a_cap_disch: assert property (p_cap_disch)
      else $error("no discharge phase");
   property p_clamp_cap;
      MODE == MD_CAP && $past(MODE, 2) == MD_CAP && AC_SELECT_PIN
      |-> RANGE >= RNG_C_CLAMP_MIN;
   endproperty
   a_clamp_cap: assert property (p_clamp_cap)
      else $error("clamp cap range too low");
endmodule : mrc_chk
bind mrc_range_ctrl mrc_chk #(.TONE_HALF(TONE_HALF)) mrc_chk_i (
   .CLK(CLK), .ARST_N(ARST_N), .STRAPS(STRAPS),
   .FUNCTION_CODE_PINS(FUNCTION_CODE_PINS), .AC_SELECT_PIN(AC_SELECT_PIN),
   .FUNC_ALT(FUNC_ALT), .MANUAL_EN(MANUAL_EN), .READING(READING),
   .READING_VALID(READING_VALID), .HIGH_CREST_DETECT(HIGH_CREST_DETECT),
   .MODE(MODE), .RANGE(RANGE), .ROUTE(ROUTE), .DISPLAY(DISPLAY),
   .BUZZER(BUZZER));
`default_nettype wire

// ### mrc_fe.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_fe (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] rng,
   input wire logic disch,
   input wire logic [31:0] level,
   output logic [13:0] reading,
   output logic valid,
   output logic discharged
);
   logic [3:0] tick_q;
   logic [3:0] dis_q;
   logic [31:0] cnt;
   // Counts follow the selected range, as the divider would scale them.
   assign cnt = level / (32'h0000_000A ** rng);
   assign discharged = dis_q == 4'h8;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick_q <= 4'h0;
         dis_q <= 4'h0;
         valid <= 1'b0;
         reading <= 14'h0000;
      end
      else
      begin
         tick_q <= tick_q + 4'h1;
         valid <= tick_q == 4'hF;
         // Between samples the bus carries junk, so stale use shows up.
         reading <= (tick_q != 4'hF) ? ~reading :
            (cnt > 32'h0000_3FFF) ? 14'h3FFF : cnt[13:0];
         dis_q <= disch ? dis_q + {3'h0, dis_q != 4'h8} : 4'h0;
      end
   end
endmodule : mrc_fe
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mrc_pkg::*;
   localparam int MS = 4;
   localparam logic [3:0] CF [7] = '{FC_AUTO_LO, FC_AUTO_HI, FC_A66,
      FC_CLAMP_6A, FC_CLAMP_66A, FC_CLAMP_660A, FC_CLAMP_6600A};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   mrc_strap_t straps = '0;
   logic [3:0] fc = FC_VOLT;
   logic ac = 1'b0;
   logic alt = 1'b0;
   logic zreq = 1'b0;
   logic high_crest_detect = 1'b0;
   logic [31:0] level = '0;
   logic [13:0] rd;
   logic [13:0] rout;
   logic rv;
   logic dis;
   logic zact;
   logic csamp;
   logic clow;
   logic buz;
   mrc_mode_t mode;
   logic [2:0] rng;
   mrc_route_t route;
   mrc_display_t disp;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   int k;
   mrc_range_ctrl #(.MS_CYC(MS), .TONE_HALF(3)) mrc_range_ctrl_i (
      .CLK(clk), .ARST_N(arst_n), .STRAPS(straps),
      .FUNCTION_CODE_PINS(fc), .AC_SELECT_PIN(ac), .FUNC_ALT(alt),
      .MANUAL_EN(1'b0), .RANGE_BTN(1'b0), .ZERO_REQ(zreq),
      .READING(rd), .READING_VALID(rv), .HIGH_CREST_DETECT(high_crest_detect),
      .DISCHARGED(dis), .MODE(mode), .RANGE(rng), .ROUTE(route),
      .DISPLAY(disp), .READING_OUT(rout), .ZERO_ACTIVE(zact),
      .CAP_LOW_CURRENT(clow), .CAP_SAMPLE(csamp), .BUZZER(buz));
   mrc_fe mrc_fe_i (.clk(clk), .arst_n(arst_n), .rng(rng),
      .disch(disp.discharge_message), .level(level), .reading(rd),
      .valid(rv), .discharged(dis));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   ////////////////////////////////////////
   task automatic end_sim;
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [13:0] e,
      input logic [13:0] g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Straps change only while reset is held.
   task automatic setup(input logic [3:0] f, input logic a,
      input logic l, input mrc_strap_t s, input logic [31:0] lv);
      @(negedge clk);
      arst_n = 1'b0;
      fc = f;
      ac = a;
      alt = l;
      straps = s;
      level = lv;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask : setup
   task automatic wait_rng(input logic [2:0] e, input int lim);
      n = 0;
      while (rng !== e && n < lim)
      begin
         n++;
         @(negedge clk);
      end
      chk("range", e, rng);
   endtask : wait_rng
   task automatic buz_chk(input logic e);
      logic s;
      s = 1'b0;
      repeat (40)
      begin
         @(negedge clk);
         s = s | (buz === 1'b1);
      end
      chk("buzzer", e, s);
   endtask : buz_chk
   ////////////////////////////////////////
   initial
   begin
      setup(FC_VOLT, 1'b0, 1'b0, 5'h00, 32'h009B_A4C0);
      chk("mode", MD_VOLT, mode);
      wait_rng(RNG_V_1000V, 200);
      repeat (20) @(negedge clk);
      chk("overload", 1'b1, disp.overload_flag);
      setup(FC_VOLT, 1'b0, 1'b0, 5'h08, 32'h009B_A4C0);
      repeat (100) @(negedge clk);
      chk("range", RNG_V_660V, rng);
      chk("overload", 1'b1, disp.overload_flag);
      setup(FC_VOLT, 1'b0, 1'b0, 5'h10, 32'h0000_03E8);
      repeat (40) @(negedge clk);
      chk("range", RNG_V_660V, rng);
      setup(FC_VOLT, 1'b1, 1'b0, 5'h00, 32'h0000_2710);
      high_crest_detect = 1'b1;
      wait_rng(RNG_V_1000V, 1000);
      chk("crest pace", 1'b1, n >= 178 * MS);
      high_crest_detect = 1'b0;
      for (int i = 0; i < 14; i++)
      begin
         k = i % 7;
         setup(CF[k], 1'b0, 1'b0, {3'h0, i >= 7, 1'b0}, 32'h0000_03E8);
         chk("mode", k < 2 ? MD_CUR_AUTO : MD_CUR_MAN, mode);
         chk("route", k < 2 ? RT_SENSE_LOW : k == 2 ? RT_SENSE_HIGH :
            RT_ADAPTER, route);
         chk("unit blank", i >= 7, disp.unit_blank);
      end
      setup(FC_CLAMP_6A, 1'b0, 1'b0, 5'h00, 32'h0000_0064);
      repeat (20) @(negedge clk);
      zreq = 1'b1;
      @(negedge clk);
      zreq = 1'b0;
      repeat (40) @(negedge clk);
      chk("zero", 1'b1, zact);
      chk("reading out", 14'h0000, rout);
      setup(FC_RES, 1'b0, 1'b0, 5'h04, 32'h23C3_4600);
      wait_rng(RNG_R_TOP, 300);
      repeat (20) @(negedge clk);
      chk("fine", 1'b1, disp.fine_resolution);
      setup(FC_CONT, 1'b0, 1'b0, 5'h00, 32'h0000_012B);
      chk("mode", MD_CONT, mode);
      buz_chk(1'b1);
      level = 32'h0000_012C;
      repeat (20) @(negedge clk);
      buz_chk(1'b0);
      setup(FC_CONT, 1'b0, 1'b0, 5'h01, 32'h0000_01F3);
      buz_chk(1'b1);
      setup(FC_CONT, 1'b0, 1'b1, 5'h00, 32'h0000_0122);
      chk("mode", MD_DIODE, mode);
      chk("range", RNG_V_6V, rng);
      buz_chk(1'b1);
      level = 32'h0000_4E2A;
      repeat (20) @(negedge clk);
      chk("overload", 1'b1, disp.overload_flag);
      setup(FC_CAP, 1'b0, 1'b0, 5'h00, 32'h0000_03E8);
      repeat (3) @(negedge clk);
      chk("discharge", 1'b1, disp.discharge_message);
      while (disp.discharge_message === 1'b1) @(negedge clk);
      n = 0;
      while (csamp !== 1'b1 && n < 2000)
      begin
         n++;
         @(negedge clk);
      end
      k = int'(CAP_PERIOD_MS[0]) * MS;
      chk("cap period", 1'b1, n + 8 > k && n < k + 8);
      setup(FC_CAP, 1'b1, 1'b0, 5'h01, 32'h0000_0000);
      repeat (40) @(negedge clk);
      chk("range", RNG_C_CLAMP_MIN, rng);
      chk("cap low", 1'b1, clow);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
